/* File: hdl/cmg_top.sv */
module cmg_top #(
  parameter logic [cmg_pkg::TB_W-1:0] WINDOW_TICKS = cmg_pkg::WINDOW_TICKS,
  parameter logic [cmg_pkg::TB_W-1:0] RECYCLE_TICKS = cmg_pkg::RECYCLE_TICKS,
  parameter logic [cmg_pkg::START_LEN-1:0] START_PATTERN = cmg_pkg::START_PATTERN_DEF,
  parameter logic PARITY_ODD = cmg_pkg::PARITY_ODD_DEF
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cycle_sync_pulse,
  input wire logic recurrent_switch,
  input wire logic single_switch,
  input wire logic slow_rate_n,
  input wire cmg_pkg::cmg_switch_t switch_n,
  input wire cmg_pkg::cmg_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  output cmg_pkg::cmg_out_t tx
);

  // Synchronisers
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] next_pin_s1;
  logic [3:0] next_pin_s2;
  cmg_pkg::cmg_switch_t sw_s1;
  cmg_pkg::cmg_switch_t sw_s2;
  cmg_pkg::cmg_switch_t next_sw_s1;
  cmg_pkg::cmg_switch_t next_sw_s2;
  // Third flop of each edge-detected pin
  logic sync_q;
  logic single_q;
  logic next_sync_q;
  logic next_single_q;
  logic sync_s;
  logic recur_s;
  logic single_s;
  logic rate_s;

  // Pins and switches pass two flops before any logic reads them
  always_comb begin
    next_pin_s1 = {cycle_sync_pulse, recurrent_switch, single_switch, slow_rate_n};
    next_pin_s2 = pin_s1;
    next_sw_s1 = switch_n;
    next_sw_s2 = sw_s1;
    next_sync_q = pin_s2[cmg_pkg::PIN_SYNC];
    next_single_q = pin_s2[cmg_pkg::PIN_SINGLE];
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      // Idle pins: no sync, no request, clock-select open
      pin_s1 <= 4'h1;
      pin_s2 <= 4'h1;
      sw_s1 <= '1;
      sw_s2 <= '1;
      sync_q <= 1'b0;
      single_q <= 1'b0;
    end else begin
      pin_s1 <= next_pin_s1;
      pin_s2 <= next_pin_s2;
      sw_s1 <= next_sw_s1;
      sw_s2 <= next_sw_s2;
      sync_q <= next_sync_q;
      single_q <= next_single_q;
    end
  end

  assign sync_s = pin_s2[cmg_pkg::PIN_SYNC];
  assign recur_s = pin_s2[cmg_pkg::PIN_RECUR];
  assign single_s = pin_s2[cmg_pkg::PIN_SINGLE];
  assign rate_s = pin_s2[cmg_pkg::PIN_RATE];

  // Control register
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  logic [31:0] next_rdata;

  // Time base
  logic [cmg_pkg::TB_ACC_W-1:0] tb_acc;
  logic [cmg_pkg::TB_ACC_W-1:0] next_tb_acc;
  logic [15:0] tb_sum;
  logic [15:0] tb_wrap;
  logic tick10;
  logic [cmg_pkg::TB_W-1:0] tb_count;
  logic [cmg_pkg::TB_W-1:0] next_tb_count;
  logic [cmg_pkg::STRETCH_W-1:0] stretch_cnt;
  logic [cmg_pkg::STRETCH_W-1:0] next_stretch_cnt;
  logic stretch_on;
  logic stretch_start;
  logic window;
  logic window_q;
  logic next_window_q;
  logic window_rise;

  always_comb begin
    // Two 10 MHz ticks in every five clocks
    tb_sum = {1'b0, tb_acc} + cmg_pkg::TB_ACC_INC;
    tb_wrap = tb_sum - cmg_pkg::TB_ACC_MOD;
    tick10 = (tb_sum >= cmg_pkg::TB_ACC_MOD);
    next_tb_acc = tick10 ? tb_wrap[cmg_pkg::TB_ACC_W-1:0] : tb_sum[cmg_pkg::TB_ACC_W-1:0];
    stretch_on = (stretch_cnt != '0);
    stretch_start = (sync_s & ~sync_q) |
      (ctrl[cmg_pkg::CTRL_STANDALONE] & tick10 & (tb_count + cmg_pkg::TB_ONE == RECYCLE_TICKS));
    next_stretch_cnt = stretch_cnt;
    if (stretch_start) begin
      next_stretch_cnt = cmg_pkg::STRETCH_TICKS;
    end else if (tick10 && stretch_on) begin
      next_stretch_cnt = stretch_cnt - 4'h1;
    end
    // Count holds at zero through the stretch and saturates without sync unless standalone recycles it at RECYCLE_TICKS
    next_tb_count = tb_count;
    if (stretch_start || stretch_on) begin
      next_tb_count = '0;
    end else if (tick10 && (tb_count != '1)) begin
      next_tb_count = tb_count + cmg_pkg::TB_ONE;
    end
    // Window drops during the stretch so no unload overlaps a load
    window = ~stretch_on & ~stretch_start & (tb_count < WINDOW_TICKS);
    next_window_q = window;
    window_rise = window & ~window_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tb_acc <= '0;
      tb_count <= '0;
      stretch_cnt <= '0;
      window_q <= 1'b0;
    end else begin
      tb_acc <= next_tb_acc;
      tb_count <= next_tb_count;
      stretch_cnt <= next_stretch_cnt;
      window_q <= next_window_q;
    end
  end

  // Bit clocks, one accumulator per rate
  logic [cmg_pkg::NCO_W-1:0] nco_acc [cmg_pkg::NRATE];
  logic [cmg_pkg::NCO_W-1:0] next_nco_acc [cmg_pkg::NRATE];
  logic [1:0] qcnt [cmg_pkg::NRATE];
  logic [1:0] next_qcnt [cmg_pkg::NRATE];
  logic [cmg_pkg::NRATE-1:0] qtick;
  logic sel_tick;

  // Bit clock is bit 1 of a quarter-period count
  for (genvar g = 0; g < cmg_pkg::NRATE; g++) begin : g_rate
    localparam logic [cmg_pkg::NCO_W:0] INC = 15'(4 * cmg_pkg::BIT_HZ[g] / 1000);
    logic [cmg_pkg::NCO_W:0] sum;
    logic [cmg_pkg::NCO_W:0] wrap;

    always_comb begin
      sum = {1'b0, nco_acc[g]} + INC;
      wrap = sum - cmg_pkg::NCO_MOD;
      qtick[g] = tick10 & (sum >= cmg_pkg::NCO_MOD);
      next_nco_acc[g] = nco_acc[g];
      if (qtick[g]) begin
        next_nco_acc[g] = wrap[cmg_pkg::NCO_W-1:0];
      end else if (tick10) begin
        next_nco_acc[g] = sum[cmg_pkg::NCO_W-1:0];
      end
      next_qcnt[g] = qtick[g] ? qcnt[g] + 2'h1 : qcnt[g];
    end

    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        nco_acc[g] <= '0;
        qcnt[g] <= 2'h0;
      end else begin
        nco_acc[g] <= next_nco_acc[g];
        qcnt[g] <= next_qcnt[g];
      end
    end
  end

  // Grounded select picks the data set rate, open picks the buffer rate
  assign sel_tick = rate_s ? qtick[cmg_pkg::RATE_500K] : qtick[cmg_pkg::RATE_200K];

  // Load word: five low-true bytes with low-true parity between them
  logic [cmg_pkg::NBYTES*8-1:0] flat_n;
  logic [cmg_pkg::DREG_W-1:0] load_word;

  assign flat_n = {sw_s2.cluster_addr, sw_s2.unit_addr, sw_s2.mux_addr, sw_s2.argument};

  for (genvar b = 0; b < cmg_pkg::NBYTES; b++) begin : g_byte
    localparam int HI = cmg_pkg::DREG_W - 1 - 9 * b;
    assign load_word[HI -: 8] = flat_n[cmg_pkg::NBYTES*8-1-8*b -: 8];
    // Parity is stored low-true like the data, so the inverted output is right
    if (b < cmg_pkg::NBYTES - 1) begin : g_par
      assign load_word[HI-8] = ~((^(~flat_n[cmg_pkg::NBYTES*8-1-8*b -: 8])) ^ PARITY_ODD);
    end
  end

  // Unload sequencing
  cmg_pkg::cmg_ul_t ul_state;
  cmg_pkg::cmg_ul_t next_ul_state;
  logic [cmg_pkg::DREG_W-1:0] dreg;
  logic [cmg_pkg::DREG_W-1:0] next_dreg;
  logic [cmg_pkg::S_W-1:0] sreg;
  logic [cmg_pkg::S_W-1:0] next_sreg;
  logic fast;
  logic slow;
  logic next_fast;
  logic next_slow;
  logic single_latch;
  logic single_flag;
  logic next_single_latch;
  logic next_single_flag;
  logic nrz;
  logic next_nrz;
  logic bp;
  logic next_bp;

  always_comb begin
    next_ul_state = ul_state;
    next_dreg = dreg;
    next_sreg = sreg;
    next_fast = fast;
    next_slow = slow;
    next_single_latch = single_latch;
    next_single_flag = single_flag;
    // Single request: latch on press, flag at window rise, cleared next cycle
    if (stretch_start) begin
      next_single_flag = 1'b0;
      if (single_flag) begin
        next_single_latch = 1'b0;
      end
    end
    if (window_rise && single_latch) begin
      next_single_flag = 1'b1;
    end
    // A press in the same cycle as the clear wins
    if (single_s && !single_q) begin
      next_single_latch = 1'b1;
    end
    // Load and clock initialisation during the stretch
    if (stretch_start || stretch_on) begin
      next_dreg = load_word;
      next_sreg = {1'b0, START_PATTERN};
      next_fast = 1'b0;
      next_slow = 1'b1;
      next_ul_state = cmg_pkg::CMG_UL_IDLE;
    end else begin
      case (ul_state)
        cmg_pkg::CMG_UL_IDLE: begin
          if (ctrl[cmg_pkg::CTRL_ENABLE] && window && tick10 &&
              (tb_count == cmg_pkg::START_TICKS) && (recur_s || single_flag)) begin
            next_ul_state = cmg_pkg::CMG_UL_ARMED;
          end
        end
        cmg_pkg::CMG_UL_ARMED, cmg_pkg::CMG_UL_RUN: begin
          // Closing window returns both unload clocks to their idle levels
          if (!window) begin
            next_ul_state = cmg_pkg::CMG_UL_IDLE;
            next_fast = 1'b0;
            next_slow = 1'b1;
          end else if (sel_tick) begin
            next_ul_state = cmg_pkg::CMG_UL_RUN;
            next_fast = ~fast;
            // Start stage shifts on fast rise, data stage on every other fall
            if (!fast) begin
              next_sreg = {sreg[cmg_pkg::S_W-2:0], ~dreg[cmg_pkg::DREG_W-1]};
            end else begin
              next_slow = ~slow;
              if (!slow) begin
                next_dreg = {dreg[cmg_pkg::DREG_W-2:0], 1'b1};
              end
            end
          end
        end
        default: begin
          next_ul_state = cmg_pkg::CMG_UL_IDLE;
        end
      endcase
    end
    // NRZ is registered one clock behind the shift stage, biphase one clock behind NRZ
    next_nrz = window & (ul_state == cmg_pkg::CMG_UL_RUN) & sreg[cmg_pkg::S_W-1];
    next_bp = window_q & (nrz ^ qcnt[cmg_pkg::RATE_500K][1]);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ul_state <= cmg_pkg::CMG_UL_IDLE;
      dreg <= '1;
      sreg <= '0;
      fast <= 1'b0;
      slow <= 1'b1;
      single_latch <= 1'b0;
      single_flag <= 1'b0;
      nrz <= 1'b0;
      bp <= 1'b0;
    end else begin
      ul_state <= next_ul_state;
      dreg <= next_dreg;
      sreg <= next_sreg;
      fast <= next_fast;
      slow <= next_slow;
      single_latch <= next_single_latch;
      single_flag <= next_single_flag;
      nrz <= next_nrz;
      bp <= next_bp;
    end
  end

  // Register port
  always_comb begin
    next_ctrl = ctrl;
    // Writes to read-only or unmapped addresses are ignored
    if (bus_req.wr && (bus_req.addr == cmg_pkg::REG_CTRL)) begin
      next_ctrl = bus_req.wdata[1:0];
    end
    // Read data stand for one cycle, zero otherwise
    next_rdata = 32'h0;
    if (bus_req.rd) begin
      if (bus_req.addr == cmg_pkg::REG_CTRL) begin
        next_rdata[1:0] = ctrl;
      end else if (bus_req.addr == cmg_pkg::REG_STATUS) begin
        next_rdata[cmg_pkg::ST_WINDOW] = window_q;
        next_rdata[cmg_pkg::ST_RUN] = (ul_state == cmg_pkg::CMG_UL_RUN);
        next_rdata[cmg_pkg::ST_LATCH] = single_latch;
        next_rdata[cmg_pkg::ST_FLAG] = single_flag;
        next_rdata[cmg_pkg::ST_SLOW] = ~rate_s;
        next_rdata[cmg_pkg::ST_RECUR] = recur_s;
      end else if (bus_req.addr == cmg_pkg::REG_COUNT) begin
        next_rdata[cmg_pkg::TB_W-1:0] = tb_count;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl <= cmg_pkg::CTRL_RESET;
      bus_rdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      bus_rdata <= next_rdata;
    end
  end

  // Every link output comes straight from a flop
  assign tx.nrz = nrz;
  assign tx.biphase_level_code = bp;
  assign tx.window = window_q;
  assign tx.fast_unload_clock = fast;
  assign tx.slow_unload_clock = slow;
  assign tx.clk_200k = qcnt[cmg_pkg::RATE_200K][1];
  assign tx.clk_500k = qcnt[cmg_pkg::RATE_500K][1];

endmodule

/* File: common/cmg_pkg.sv */
package cmg_pkg;
  // Clocks and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int TB_HZ = 10_000_000;
  localparam int TB_ACC_W = 15;
  localparam logic [15:0] TB_ACC_INC = 16'(TB_HZ / 1000);
  localparam logic [15:0] TB_ACC_MOD = 16'(CLK_HZ / 1000);
  localparam int TB_TICKS_PER_US = TB_HZ / 1_000_000;
  localparam int TB_W = 20;
  localparam logic [TB_W-1:0] TB_ONE = 20'h1;
  // Times in their own units
  localparam int WINDOW_US = 1000;
  localparam int CYCLE_US_X10 = 520_833;
  localparam int START_US = 200;
  localparam int TRANSIENT_US = 50;
  localparam int RECYCLE_US = 54_200;
  localparam int SYNC_IN_NS = 400;
  localparam int STRETCH_NS = 1000;
  // Derived counts of 10 MHz ticks
  localparam logic [TB_W-1:0] WINDOW_TICKS = TB_W'(WINDOW_US * TB_TICKS_PER_US);
  localparam logic [TB_W-1:0] START_TICKS = TB_W'(START_US * TB_TICKS_PER_US);
  localparam logic [TB_W-1:0] RECYCLE_TICKS = TB_W'(RECYCLE_US * TB_TICKS_PER_US);
  localparam int STRETCH_W = 4;
  localparam logic [STRETCH_W-1:0] STRETCH_TICKS =
    STRETCH_W'((STRETCH_NS * TB_TICKS_PER_US + 999) / 1000);
  // Bit clocks, quarter-period ticks from a phase accumulator
  localparam int NRATE = 2;
  localparam int RATE_200K = 0;
  localparam int RATE_500K = 1;
  localparam int BIT_HZ [NRATE] = '{200_000, 500_000};
  localparam int NCO_W = 14;
  localparam logic [NCO_W:0] NCO_MOD = 15'(TB_HZ / 1000);
  // Message layout
  localparam int NBYTES = 5;
  localparam int DREG_W = NBYTES * 9 - 1;
  localparam int START_LEN = 4;
  localparam int S_W = START_LEN + 1;
  localparam logic [START_LEN-1:0] START_PATTERN_DEF = 4'hb;
  localparam logic PARITY_ODD_DEF = 1'b1;
  // Pin bit positions in the synchroniser
  localparam int PIN_SYNC = 3;
  localparam int PIN_RECUR = 2;
  localparam int PIN_SINGLE = 1;
  localparam int PIN_RATE = 0;
  // Registers
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_COUNT = 4'h8;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_STANDALONE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_WINDOW = 0;
  localparam int ST_RUN = 1;
  localparam int ST_LATCH = 2;
  localparam int ST_FLAG = 3;
  localparam int ST_SLOW = 4;
  localparam int ST_RECUR = 5;

  typedef struct packed {
    logic [4:0] cluster_addr;
    logic [2:0] unit_addr;
    logic [7:0] mux_addr;
    logic [23:0] argument;
  } cmg_switch_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cmg_bus_req_t;

  typedef struct packed {
    logic nrz;
    logic biphase_level_code;
    logic window;
    logic fast_unload_clock;
    logic slow_unload_clock;
    logic clk_200k;
    logic clk_500k;
  } cmg_out_t;

  typedef enum logic [1:0] {
    CMG_UL_IDLE = 2'h0,
    CMG_UL_ARMED = 2'h1,
    CMG_UL_RUN = 2'h3
  } cmg_ul_t;
endpackage

/* File: tb/cmg_rx_model.sv */
// Far-side receiver: samples the NRZ stream midway in each fast unload period
module cmg_rx_model (
  input wire logic clk_sys,
  input wire logic fast_unload_clock,
  input wire logic nrz
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fast_d = 1'b0;
  logic samp[$];
  always @(posedge clk_sys) begin
    if (fast_d && !fast_unload_clock) samp.push_back(nrz);
    fast_d <= fast_unload_clock;
  end
endmodule

/* File: tb/cmg_props.sv */
module cmg_props #(
  parameter logic [cmg_pkg::TB_W-1:0] WINDOW_TICKS = cmg_pkg::WINDOW_TICKS
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cycle_sync_pulse,
  input wire cmg_pkg::cmg_out_t tx
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WC = 5 * int'(WINDOW_TICKS) / 2;
  int win_cnt;
  int sync_age;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk_sys) begin
    if (!nrst) win_cnt <= 0;
    else win_cnt <= tx.window ? win_cnt + 1 : 0;
  end
  // Cycles since the sync pin was last high; a new sync may cut a window short
  always_ff @(posedge clk_sys) begin
    if (!nrst) sync_age <= 0;
    else if (cycle_sync_pulse) sync_age <= 0;
    else if (sync_age < 100) sync_age <= sync_age + 1;
  end
  property p_rst;
    $rose(nrst) |-> tx.slow_unload_clock && !tx.fast_unload_clock && !tx.nrz;
  endproperty
  a_rst: assert property (p_rst) else $error("unload clocks wrong after reset");
  property p_sync_clear;
    $rose(cycle_sync_pulse) |-> ##6 (!tx.window) [*8];
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("window not cleared by sync");
  property p_sync_win;
    $rose(cycle_sync_pulse) |-> ##[20:40] tx.window;
  endproperty
  a_sync_win: assert property (p_sync_win) else $error("window late after sync");
  property p_idle_nrz;
    !tx.window |-> !tx.nrz;
  endproperty
  a_idle_nrz: assert property (p_idle_nrz) else $error("nrz active outside window");
  property p_idle_fast;
    !tx.window && !$past(tx.window) |-> !tx.fast_unload_clock;
  endproperty
  a_idle_fast: assert property (p_idle_fast) else $error("unload clock outside window");
  property p_slow;
    $fell(tx.fast_unload_clock) && tx.window && win_cnt < WC - 20
      |-> ##[0:1] $changed(tx.slow_unload_clock);
  endproperty
  a_slow: assert property (p_slow) else $error("slow clock did not toggle");
  property p_win_len;
    $fell(tx.window) && sync_age > 40
      |-> 2 * win_cnt >= 2 * WC - 8 && 2 * win_cnt <= 2 * WC + 8;
  endproperty
  a_win_len: assert property (p_win_len) else $error("window length wrong");
  property p_start;
    $rose(tx.fast_unload_clock) |-> tx.window && win_cnt >= 4990;
  endproperty
  a_start: assert property (p_start) else $error("unload started early");
  property p_bi;
    tx.window && $past(tx.window)
      |-> tx.biphase_level_code == ($past(tx.nrz) ^ $past(tx.clk_500k));
  endproperty
  a_bi: assert property (p_bi) else $error("biphase code wrong");
  property p_clk200;
    $rose(tx.clk_200k) |-> ##125 $rose(tx.clk_200k);
  endproperty
  a_clk200: assert property (p_clk200) else $error("200 kHz bit clock period wrong");
  property p_clk500;
    $rose(tx.clk_500k) |-> ##50 $rose(tx.clk_500k);
  endproperty
  a_clk500: assert property (p_clk500) else $error("500 kHz bit clock period wrong");
  c_fast: cover property ($rose(tx.fast_unload_clock));
  c_win: cover property ($fell(tx.window));
  c_bi: cover property ($rose(tx.biphase_level_code) && tx.nrz);
endmodule
bind cmg_top cmg_props #(.WINDOW_TICKS(WINDOW_TICKS)) cmg_props_inst (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .cycle_sync_pulse(cycle_sync_pulse),
  .tx(tx)
);

/* File: tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] WT = 20'h011f8;
  localparam logic [19:0] RT = 20'h01388;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cycle_sync_pulse = 1'b0;
  logic recurrent_switch = 1'b1;
  logic single_switch = 1'b0;
  logic slow_rate_n = 1'b1;
  cmg_pkg::cmg_switch_t switch_n = '1;
  cmg_pkg::cmg_bus_req_t bus_req = '0;
  logic [31:0] bus_rdata;
  cmg_pkg::cmg_out_t tx;
  logic [31:0] rd_v;
  int err_count = 0;
  int total_checks = 0;
  cmg_top #(.WINDOW_TICKS(WT), .RECYCLE_TICKS(RT)) cmg_top_inst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .cycle_sync_pulse(cycle_sync_pulse),
    .recurrent_switch(recurrent_switch),
    .single_switch(single_switch),
    .slow_rate_n(slow_rate_n),
    .switch_n(switch_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .tx(tx)
  );
  cmg_rx_model cmg_rx_model_inst (
    .clk_sys(clk_sys),
    .fast_unload_clock(tx.fast_unload_clock),
    .nrz(tx.nrz)
  );
  initial forever #20 clk_sys = ~clk_sys;
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task bus_wr(input logic [3:0] a, input logic [31:0] d);
    bus_req <= cmg_pkg::cmg_bus_req_t'{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
  endtask
  task bus_rd(input logic [3:0] a);
    bus_req <= cmg_pkg::cmg_bus_req_t'{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
    rd_v = bus_rdata;
  endtask
  // One machine cycle; leaves the mid-cycle status word in rd_v
  task run_cycle;
    cmg_rx_model_inst.samp.delete();
    cycle_sync_pulse <= 1'b1;
    repeat (12) @(posedge clk_sys);
    cycle_sync_pulse <= 1'b0;
    repeat (6000) @(posedge clk_sys);
    bus_rd(cmg_pkg::REG_COUNT);
    chk(32'(rd_v > 32'd2380 && rd_v < 32'd2410), 32'h1);
    bus_rd(cmg_pkg::REG_STATUS);
    repeat (6000) @(posedge clk_sys);
  endtask
  task check_msg(input logic [39:0] v);
    logic [43:0] m;
    int p;
    int s;
    int n;
    p = 43;
    s = -1;
    for (int i = 0; i < 5; i++) begin
      for (int j = 7; j >= 0; j--) begin
        m[p] = v[32 - 8 * i + j];
        p--;
      end
      if (i < 4) begin
        m[p] = ~^v[32 - 8 * i +: 8];
        p--;
      end
    end
    n = cmg_rx_model_inst.samp.size();
    for (int k = n - 1; k >= 0; k--) if (cmg_rx_model_inst.samp[k] === 1'b1) s = k;
    chk(32'(s >= 0 && n >= s + 92), 32'h1);
    if (s < 0 || n < s + 92) return;
    for (int k = 0; k < 4; k++) begin
      chk(32'(cmg_rx_model_inst.samp[s + k]), 32'(cmg_pkg::START_PATTERN_DEF[3 - k]));
    end
    for (int k = 0; k < 44; k++) begin
      chk(32'({cmg_rx_model_inst.samp[s + 4 + 2 * k], cmg_rx_model_inst.samp[s + 5 + 2 * k]}),
        32'({2{m[43 - k]}}));
    end
    for (int k = s + 92; k < n; k++) chk(32'(cmg_rx_model_inst.samp[k]), 32'h0);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    bus_rd(cmg_pkg::REG_CTRL);
    chk(rd_v, 32'h1);
    bus_rd(4'hc);
    chk(rd_v, 32'h0);
    bus_wr(cmg_pkg::REG_CTRL, 32'hfffffffc);
    bus_rd(cmg_pkg::REG_CTRL);
    chk(rd_v, 32'h0);
    run_cycle();
    chk(32'(cmg_rx_model_inst.samp.size()), 32'h0);
    $display("registers and disabled cycle done");
    bus_wr(cmg_pkg::REG_CTRL, 32'h1);
    switch_n <= ~40'hc5a31234f1;
    run_cycle();
    chk(32'(rd_v[5:4]), 32'h2);
    check_msg(40'hc5a31234f1);
    $display("recurrent fast rate done");
    slow_rate_n <= 1'b0;
    switch_n <= ~40'h3e8100ff7e;
    run_cycle();
    chk(32'(rd_v[5:4]), 32'h3);
    check_msg(40'h3e8100ff7e);
    $display("recurrent slow rate done");
    recurrent_switch <= 1'b0;
    slow_rate_n <= 1'b1;
    single_switch <= 1'b1;
    repeat (20) @(posedge clk_sys);
    single_switch <= 1'b0;
    run_cycle();
    check_msg(40'h3e8100ff7e);
    run_cycle();
    chk(32'(cmg_rx_model_inst.samp.size()), 32'h0);
    $display("single shot done");
    bus_wr(cmg_pkg::REG_CTRL, 32'h3);
    repeat (14000) @(posedge clk_sys);
    bus_rd(cmg_pkg::REG_COUNT);
    chk(32'(rd_v < 32'(RT)), 32'h1);
    $display("standalone recycle done");
    end_sim();
  end
endmodule
